//--- core/rss_device.sv
`timescale 1ns/100ps
module rss_device #(
  parameter int unsigned SETTLE_CYC = rss_pkg::SETTLE_CYC,
  parameter int unsigned HOP_CYC = rss_pkg::HOP_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  rss_link_if.device LINK,
  output logic [7:0] REF_DIV,
  output logic [7:0] FB_DIV,
  output logic [7:0] SWALLOW_DIV,
  output logic [7:0] RX_FILTER,
  output logic SET_SEL,
  output logic RX_ENABLE,
  output logic READY
);
  import rss_pkg::*;

  typedef enum logic [1:0] {
    DS_POR = 2'b00,
    DS_RUN = 2'b01,
    DS_MRST = 2'b10
  } rss_dstate_e;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  assign pin_raw = {LINK.mrst_pin, LINK.mosi, LINK.sck, LINK.cs_n};
  rss_pin_sync #(.WIDTH(4), .RESET_VAL(4'h1)) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .PIN_IN(pin_raw),
    .PIN_OUT(pin_s)
  );
  wire cs_n_s = pin_s[0];
  wire sck_s = pin_s[1];
  wire mosi_s = pin_s[2];
  wire mrst_s = pin_s[3];

  rss_dstate_e st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] lock_cnt_ff;
  logic [CNT_W-1:0] ck_cnt_ff;
  logic sck_d_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [4:0] bit_ff;
  logic [7:0] div_ff [DIV_COUNT];
  logic [1:0] ctrl_ff;
  logic [7:0] filt_ff;
  logic [7:0] out_ff [DIV_SET_SIZE];
  logic lock_ff;
  logic clkout_ff;

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  wire running = (st_ff == DS_RUN);
  wire sck_rise = sck_s & ~sck_d_ff & ~cs_n_s & running;
  wire [FRAME_BITS-1:0] word = {shift_ff[FRAME_BITS-2:0], mosi_s};
  wire wr_stb = sck_rise & (bit_ff == 5'(FRAME_BITS - 1));
  wire [7:0] wr_addr = word[15:8];
  wire [7:0] wr_data = word[7:0];
  wire div_hit = wr_stb & (wr_addr >= ADDR_DIV_FIRST) &
                 (wr_addr <= ADDR_DIV_LAST);
  wire [2:0] div_idx = 3'(wr_addr - ADDR_DIV_FIRST);
  wire ctrl_hit = wr_stb & (wr_addr == ADDR_SYNTH_CTRL);
  wire filt_hit = wr_stb & (wr_addr == ADDR_RX_FILTER);
  wire div_in_active = (div_idx / 3'(DIV_SET_SIZE)) ==
                       {2'b00, ctrl_ff[CTRL_SET_SEL_BIT]};
  wire set_change = ctrl_hit &
    (wr_data[CTRL_SET_SEL_BIT] != ctrl_ff[CTRL_SET_SEL_BIT]);
  // Hop with receiver kept on relocks faster, at higher current
  wire rx_hop = set_change & ctrl_ff[CTRL_RX_EN_BIT] &
                wr_data[CTRL_RX_EN_BIT];
  wire relock = set_change | (div_hit & div_in_active);
  wire [CNT_W-1:0] nxt_lock_load = rx_hop ? CNT_W'(HOP_CYC)
                                          : CNT_W'(SETTLE_CYC);
  wire [2:0] act_base = ctrl_ff[CTRL_SET_SEL_BIT] ? 3'(DIV_SET_SIZE)
                                                  : 3'd0;

  // ---------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= DS_POR;
      cnt_ff <= '0;
    end else if (mrst_s) begin
      st_ff <= DS_MRST;
      cnt_ff <= '0;
    end else if (!running) begin
      cnt_ff <= cnt_ff + 1'b1;
      if (st_ff == DS_POR && cnt_ff == CNT_W'(DEV_POR_CYC - 1)) begin
        st_ff <= DS_RUN;
      end else if (st_ff != DS_POR &&
                   cnt_ff == CNT_W'(DEV_RECOVER_CYC - 1)) begin
        st_ff <= DS_RUN;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial shift and configuration store
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sck_d_ff <= 1'b0;
      shift_ff <= '0;
      bit_ff <= '0;
    end else begin
      sck_d_ff <= sck_s;
      if (cs_n_s || !running) begin
        bit_ff <= '0;
      end else if (sck_rise) begin
        shift_ff <= word;
        bit_ff <= wr_stb ? 5'd0 : bit_ff + 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DIV_COUNT; g++) begin : g_div
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          div_ff[g] <= DIV_RESET;
        end else if (!running) begin
          div_ff[g] <= DIV_RESET;
        end else if (div_hit && div_idx == 3'(g)) begin
          div_ff[g] <= wr_data;
        end
      end
    end
    for (g = 0; g < DIV_SET_SIZE; g++) begin : g_out
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) out_ff[g] <= DIV_RESET;
        else out_ff[g] <= div_ff[3'(g) + act_base];
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_ff <= CTRL_RESET;
      filt_ff <= FILT_RESET;
    end else if (!running) begin
      ctrl_ff <= CTRL_RESET;
      filt_ff <= FILT_RESET;
    end else begin
      if (ctrl_hit) ctrl_ff <= wr_data[1:0];
      if (filt_hit) filt_ff <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Lock detect and clock output
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lock_cnt_ff <= '0;
      lock_ff <= 1'b0;
    end else if (!running) begin
      lock_cnt_ff <= CNT_W'(SETTLE_CYC);
      lock_ff <= 1'b0;
    end else if (relock) begin
      lock_cnt_ff <= nxt_lock_load;
      lock_ff <= 1'b0;
    end else if (lock_cnt_ff != '0) begin
      lock_cnt_ff <= lock_cnt_ff - 1'b1;
    end else begin
      lock_ff <= 1'b1;
    end
  end

  // Clock output runs only out of reset, so any edge means running, not READY
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ck_cnt_ff <= '0;
      clkout_ff <= 1'b0;
    end else if (!running) begin
      ck_cnt_ff <= '0;
      clkout_ff <= 1'b0;
    end else if (ck_cnt_ff == CNT_W'(CLKOUT_HALF - 1)) begin
      ck_cnt_ff <= '0;
      clkout_ff <= ~clkout_ff;
    end else begin
      ck_cnt_ff <= ck_cnt_ff + 1'b1;
    end
  end

  assign LINK.clkout = clkout_ff;
  assign LINK.lock_det = lock_ff;
  assign REF_DIV = out_ff[0];
  assign FB_DIV = out_ff[1];
  assign SWALLOW_DIV = out_ff[2];
  assign RX_FILTER = filt_ff;
  assign SET_SEL = ctrl_ff[CTRL_SET_SEL_BIT];
  assign RX_ENABLE = ctrl_ff[CTRL_RX_EN_BIT];
  assign READY = lock_ff;
endmodule // rss_device

//--- core/rss_host.sv
`timescale 1ns/100ps
module rss_host #(
  parameter int unsigned POR_WAIT_CYC = rss_pkg::POR_WAIT_CYC,
  parameter int unsigned MRST_PULSE_CYC = rss_pkg::MRST_PULSE_CYC,
  parameter int unsigned MRST_WAIT_CYC = rss_pkg::MRST_WAIT_CYC,
  parameter int unsigned SETTLE_MAX_CYC = rss_pkg::SETTLE_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  rss_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [7:0] CMD_DATA,
  input wire logic PRESET_VALID,
  input wire rss_pkg::rss_rate_e PRESET_RATE,
  input wire logic MRST_REQ,
  output logic DEV_READY,
  output logic LOCKED,
  output logic SETTLE_TIMEOUT
);
  import rss_pkg::*;

  typedef enum logic [2:0] {
    HS_POR_WAIT = 3'b000,
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_GAP = 3'b011,
    HS_SETTLE = 3'b100,
    HS_MRST_PULSE = 3'b101,
    HS_MRST_WAIT = 3'b110
  } rss_hstate_e;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [1:0] pin_s;
  rss_pin_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .PIN_IN({LINK.lock_det, LINK.clkout}),
    .PIN_OUT(pin_s)
  );
  wire clkout_s = pin_s[0];
  wire lock_s = pin_s[1];

  rss_hstate_e st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [4:0] bit_ff;
  logic cs_n_ff;
  logic sck_ff;
  logic mrst_oe_ff;
  logic settle_ff;
  logic clk_d_ff;
  logic [1:0] edge_ff;
  logic ready_ff;
  logic locked_ff;
  logic tout_ff;

  // ---------------------------------------------------------------
  // Request selection
  // ---------------------------------------------------------------
  logic [7:0] preset_code;
  always_comb begin
    case (PRESET_RATE)
      RATE_FSK_100K: preset_code = FILT_FSK_100K;
      RATE_FSK_25K: preset_code = FILT_FSK_25K;
      RATE_FSK_2K: preset_code = FILT_FSK_2K;
      RATE_OOK_HIGH: preset_code = FILT_OOK_HIGH;
      RATE_OOK_LOW: preset_code = FILT_OOK_LOW;
      default: preset_code = FILT_RESET;
    endcase
  end

  wire idle = (st_ff == HS_IDLE);
  wire take_mrst = idle & MRST_REQ;
  wire take_preset = idle & ~MRST_REQ & PRESET_VALID;
  wire take_cmd = idle & ~MRST_REQ & ~PRESET_VALID & CMD_VALID;
  wire [7:0] sel_addr = take_preset ? ADDR_RX_FILTER : CMD_ADDR;
  wire [7:0] sel_data = take_preset ? preset_code : CMD_DATA;
  // Divider or set changes move the synthesizer, so wait for lock
  wire sel_settle = (sel_addr == ADDR_SYNTH_CTRL) |
    ((sel_addr >= ADDR_DIV_FIRST) & (sel_addr <= ADDR_DIV_LAST));
  wire half_done = (cnt_ff == CNT_W'(SCK_HALF - 1));
  wire last_bit = (bit_ff == 5'(FRAME_BITS - 1));
  // Two clock output edges prove the device left reset
  wire clk_seen = (edge_ff == 2'd2);
  wire clk_edge = clkout_s ^ clk_d_ff;
  wire por_done = (cnt_ff == CNT_W'(POR_WAIT_CYC - 1));
  wire mrst_done = (cnt_ff == CNT_W'(MRST_WAIT_CYC - 1));
  wire pulse_done = (cnt_ff == CNT_W'(MRST_PULSE_CYC - 1));
  wire settle_max = (cnt_ff == CNT_W'(SETTLE_MAX_CYC - 1));

  assign CMD_READY = idle & ~MRST_REQ & ~PRESET_VALID;

  // ---------------------------------------------------------------
  // Clock output activity
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      clk_d_ff <= 1'b0;
      edge_ff <= '0;
    end else begin
      clk_d_ff <= clkout_s;
      if (st_ff == HS_MRST_PULSE) edge_ff <= '0;
      else if (clk_edge && !clk_seen) edge_ff <= edge_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= HS_POR_WAIT;
      cnt_ff <= '0;
      shift_ff <= '0;
      bit_ff <= '0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      mrst_oe_ff <= 1'b0;
      settle_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      case (st_ff)
        HS_POR_WAIT: begin
          // Pin stays released and bus quiet all through
          mrst_oe_ff <= 1'b0;
          if (por_done || clk_seen) begin
            st_ff <= HS_IDLE;
          end
        end
        HS_IDLE: begin
          cnt_ff <= '0;
          if (take_mrst) begin
            st_ff <= HS_MRST_PULSE;
            mrst_oe_ff <= 1'b1;
          end else if (take_preset || take_cmd) begin
            st_ff <= HS_SHIFT;
            shift_ff <= {sel_addr, sel_data};
            settle_ff <= sel_settle;
            bit_ff <= '0;
            cs_n_ff <= 1'b0;
          end
        end
        HS_SHIFT: begin
          if (half_done) begin
            cnt_ff <= '0;
            sck_ff <= ~sck_ff;
            if (sck_ff) begin
              shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};
              bit_ff <= bit_ff + 1'b1;
              if (last_bit) begin
                st_ff <= HS_GAP;
                cs_n_ff <= 1'b1;
              end
            end
          end
        end
        HS_GAP: begin
          // Gap lets lock drop before it is watched again
          if (cnt_ff == CNT_W'(GAP_CYC - 1)) begin
            cnt_ff <= '0;
            st_ff <= settle_ff ? HS_SETTLE : HS_IDLE;
          end
        end
        HS_SETTLE: begin
          if (lock_s || settle_max) begin
            st_ff <= HS_IDLE;
          end
        end
        HS_MRST_PULSE: begin
          if (pulse_done) begin
            cnt_ff <= '0;
            mrst_oe_ff <= 1'b0;
            st_ff <= HS_MRST_WAIT;
          end
        end
        HS_MRST_WAIT: begin
          if (mrst_done || clk_seen) begin
            st_ff <= HS_IDLE;
          end
        end
        default: begin
          st_ff <= HS_POR_WAIT;
          cnt_ff <= '0;
          cs_n_ff <= 1'b1;
          sck_ff <= 1'b0;
          mrst_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ready_ff <= 1'b0;
      locked_ff <= 1'b0;
      tout_ff <= 1'b0;
    end else begin
      ready_ff <= (st_ff != HS_POR_WAIT) && (st_ff != HS_MRST_PULSE) &&
                  (st_ff != HS_MRST_WAIT);
      locked_ff <= lock_s;
      if (st_ff == HS_SETTLE && !lock_s && settle_max) tout_ff <= 1'b1;
      else if (st_ff == HS_SETTLE && lock_s) tout_ff <= 1'b0;
    end
  end

  assign LINK.cs_n = cs_n_ff;
  assign LINK.sck = sck_ff;
  assign LINK.mosi = shift_ff[FRAME_BITS-1];
  assign LINK.mrst_o = 1'b1;
  assign LINK.mrst_oe = mrst_oe_ff;
  assign DEV_READY = ready_ff;
  assign LOCKED = locked_ff;
  assign SETTLE_TIMEOUT = tout_ff;
endmodule // rss_host

//--- core/rss_link_if.sv
`timescale 1ns/100ps
interface rss_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic clkout;
  logic lock_det;
  logic mrst_o;
  logic mrst_oe;
  logic mrst_pin;

  // Undriven pin reads low, as with the on-chip pull-down
  assign mrst_pin = mrst_oe & mrst_o;

  modport host (
    output cs_n, sck, mosi, mrst_o, mrst_oe,
    input clkout, lock_det
  );
  modport device (
    input cs_n, sck, mosi, mrst_pin,
    output clkout, lock_det
  );
endinterface

//--- core/rss_pin_sync.sv
`timescale 1ns/100ps
module rss_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_OUT
);
  // -------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic out_ff;
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          s1_ff <= RESET_VAL[g];
          s2_ff <= RESET_VAL[g];
          s3_ff <= RESET_VAL[g];
          out_ff <= RESET_VAL[g];
        end else begin
          s1_ff <= PIN_IN[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) out_ff <= s3_ff;
        end
      end
      assign PIN_OUT[g] = out_ff;
    end
  endgenerate
endmodule // rss_pin_sync

//--- core/rss_pkg.sv
package rss_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned POR_WAIT_MS = 10;
  localparam int unsigned MRST_PULSE_US = 100;
  localparam int unsigned MRST_WAIT_MS = 5;
  localparam int unsigned SYNTH_SETTLE_US = 150;
  localparam int unsigned RX_HOP_US = 20;
  localparam int unsigned DEV_POR_NS = 8000;
  localparam int unsigned DEV_RECOVER_NS = 8000;
  localparam int unsigned POR_WAIT_CYC = POR_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned MRST_PULSE_CYC = MRST_PULSE_US * CLK_MHZ;
  localparam int unsigned MRST_WAIT_CYC = MRST_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned SETTLE_CYC = SYNTH_SETTLE_US * CLK_MHZ;
  localparam int unsigned HOP_CYC = RX_HOP_US * CLK_MHZ;
  localparam int unsigned DEV_POR_CYC = (DEV_POR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEV_RECOVER_CYC =
    (DEV_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLKOUT_HALF = 8;
  localparam int unsigned SCK_HALF = 4;
  localparam int unsigned GAP_CYC = 8;
  localparam int unsigned CNT_W = 24;

  // ---------------------------------------------------------------
  // Configuration word layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [7:0] ADDR_SYNTH_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV_FIRST = 8'h06;
  localparam logic [7:0] ADDR_DIV_LAST = 8'h0b;
  localparam logic [7:0] ADDR_RX_FILTER = 8'h10;
  localparam int unsigned CTRL_SET_SEL_BIT = 0;
  localparam int unsigned CTRL_RX_EN_BIT = 1;
  localparam int unsigned DIV_SET_SIZE = 3;
  localparam int unsigned DIV_COUNT = 6;

  // ---------------------------------------------------------------
  // Reset values and filter codes
  // ---------------------------------------------------------------
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] FILT_RESET = 8'ha3;
  localparam logic [7:0] FILT_FSK_100K = 8'hff;
  localparam logic [7:0] FILT_FSK_25K = 8'ha3;
  localparam logic [7:0] FILT_FSK_2K = 8'h41;
  localparam logic [7:0] FILT_OOK_HIGH = 8'hc1;
  localparam logic [7:0] FILT_OOK_LOW = 8'ha0;

  typedef enum logic [2:0] {
    RATE_FSK_100K = 3'b000,
    RATE_FSK_25K = 3'b001,
    RATE_FSK_2K = 3'b010,
    RATE_OOK_HIGH = 3'b011,
    RATE_OOK_LOW = 3'b100
  } rss_rate_e;

endpackage

//--- tb/rss_link_properties.sv
`timescale 1ns/100ps
module rss_link_properties #(
  parameter int unsigned MRST_PULSE_CYC = 200
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic clkout,
  input wire logic lock_det,
  input wire logic mrst_o,
  input wire logic mrst_oe,
  input wire logic mrst_pin
);
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [11:0] por_cnt_ff;
  logic [11:0] rel_cnt_ff;
  logic [11:0] oe_cnt_ff;
  logic [4:0] rise_cnt_ff;
  logic sck_d_ff;
  logic clk_seen_ff;
  // Saturating, so a long run never wraps back into the quiet window
  wire logic [11:0] nxt_por_cnt = por_cnt_ff + {11'h000, ~&por_cnt_ff};
  wire logic [11:0] nxt_rel_cnt =
    mrst_oe ? 12'h000 : rel_cnt_ff + {11'h000, ~&rel_cnt_ff};
  wire logic [11:0] nxt_oe_cnt = mrst_oe ? oe_cnt_ff + 12'h001 : 12'h000;
  wire logic [4:0] nxt_rise_cnt =
    cs_n ? 5'h00 : rise_cnt_ff + {4'h0, sck & ~sck_d_ff};

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      por_cnt_ff <= 12'h000;
      rel_cnt_ff <= 12'hfff;
      oe_cnt_ff <= 12'h000;
      rise_cnt_ff <= 5'h00;
      sck_d_ff <= 1'b0;
      clk_seen_ff <= 1'b0;
    end else begin
      por_cnt_ff <= nxt_por_cnt;
      rel_cnt_ff <= nxt_rel_cnt;
      oe_cnt_ff <= nxt_oe_cnt;
      rise_cnt_ff <= nxt_rise_cnt;
      sck_d_ff <= sck;
      clk_seen_ff <= clk_seen_ff | clkout;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  sequence s_pin_held;
    mrst_pin [*8];
  endsequence
  sequence s_frame_end;
    !cs_n ##1 cs_n;
  endsequence

  property p_por_float;
    por_cnt_ff < 12'h3e8 |-> !mrst_oe && cs_n;
  endproperty
  property p_por_dark;
    por_cnt_ff < 12'h3de |-> !clkout;
  endproperty
  property p_por_live;
    por_cnt_ff == 12'h44c |-> clk_seen_ff;
  endproperty
  property p_pin_drive;
    mrst_oe |-> mrst_o && mrst_pin;
  endproperty
  property p_pulse_len;
    $fell(mrst_oe) |-> oe_cnt_ff == 12'(MRST_PULSE_CYC);
  endproperty
  property p_rel_wait;
    rel_cnt_ff < 12'h3e8 |-> cs_n;
  endproperty
  property p_pin_stop;
    s_pin_held |=> !clkout;
  endproperty
  property p_frame;
    s_frame_end |-> rise_cnt_ff == 5'h10;
  endproperty
  property p_mosi_hold;
    !cs_n && sck && $past(sck) |-> $stable(mosi);
  endproperty
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_lock_back;
    $fell(lock_det) && !mrst_pin |-> ##[1:310] lock_det;
  endproperty

  a_por_float: assert property (p_por_float)
    else $error("bus or reset pin active during power-on");
  a_por_dark: assert property (p_por_dark)
    else $error("clock output active before power-on ends");
  a_por_live: assert property (p_por_live)
    else $error("clock output idle after power-on");
  a_pin_drive: assert property (p_pin_drive)
    else $error("reset pin not driven high");
  a_pulse_len: assert property (p_pulse_len)
    else $error("manual reset pulse length wrong");
  a_rel_wait: assert property (p_rel_wait)
    else $error("frame too soon after manual reset");
  a_pin_stop: assert property (p_pin_stop)
    else $error("clock output runs during manual reset");
  a_frame: assert property (p_frame)
    else $error("frame without sixteen clock rises");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data changed while clock high");
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock active outside frame");
  a_lock_back: assert property (p_lock_back)
    else $error("lock not regained in time");
endmodule // rss_link_properties

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
  import rss_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed outputs
  // ---------------------------------------------------------------
  localparam int unsigned PULSE = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic preset_valid = 1'b0;
  rss_rate_e preset_rate = RATE_FSK_100K;
  logic mrst_req = 1'b0;
  logic cmd_ready, dev_ready, locked, settle_to;
  logic [7:0] ref_div, fb_div, sw_div, rx_filter;
  logic set_sel, rx_enable, ready;
  logic [7:0] exp_div [6];
  logic [7:0] val;
  int err_total = 0;
  int n_checks = 0;
  int cyc;
  time t0, t_slow;

  always #4 clk = ~clk;

  rss_link_if rss_link_if_inst ();
  rss_host #(.POR_WAIT_CYC(3000), .MRST_PULSE_CYC(PULSE),
    .MRST_WAIT_CYC(3000), .SETTLE_MAX_CYC(500)) rss_host_inst (
    .CLK(clk), .NRST(nrst), .LINK(rss_link_if_inst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_ADDR(cmd_addr),
    .CMD_DATA(cmd_data), .PRESET_VALID(preset_valid),
    .PRESET_RATE(preset_rate), .MRST_REQ(mrst_req),
    .DEV_READY(dev_ready), .LOCKED(locked), .SETTLE_TIMEOUT(settle_to));
  rss_device #(.SETTLE_CYC(300), .HOP_CYC(100)) rss_device_inst (
    .CLK(clk), .NRST(nrst), .LINK(rss_link_if_inst),
    .REF_DIV(ref_div), .FB_DIV(fb_div), .SWALLOW_DIV(sw_div),
    .RX_FILTER(rx_filter), .SET_SEL(set_sel), .RX_ENABLE(rx_enable),
    .READY(ready));
  rss_link_properties #(.MRST_PULSE_CYC(PULSE)) rss_link_properties_inst (
    .CLK(clk), .NRST(nrst), .cs_n(rss_link_if_inst.cs_n),
    .sck(rss_link_if_inst.sck), .mosi(rss_link_if_inst.mosi),
    .clkout(rss_link_if_inst.clkout), .lock_det(rss_link_if_inst.lock_det),
    .mrst_o(rss_link_if_inst.mrst_o), .mrst_oe(rss_link_if_inst.mrst_oe),
    .mrst_pin(rss_link_if_inst.mrst_pin));

  // ---------------------------------------------------------------
  // Checking and driving tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Bounded, so a stuck handshake shows as a mismatch
  task automatic wait_sig(input logic dev, input logic lvl);
    int i;
    i = 0;
    while ((dev ? dev_ready : cmd_ready) !== lvl && i < 5000) begin
      @(negedge clk);
      i++;
    end
    if (i == 5000) chk1(1'b0, 1'b1);
  endtask

  task automatic send(input logic pre, input rss_rate_e r,
                      input logic [7:0] a, input logic [7:0] d);
    wait_sig(1'b0, 1'b1);
    preset_valid = pre;
    cmd_valid = !pre;
    preset_rate = r;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clk);
    preset_valid = 1'b0;
    cmd_valid = 1'b0;
    @(negedge clk);
    wait_sig(1'b0, 1'b1);
  endtask

  task automatic chk_set(input int b);
    chk8(ref_div, exp_div[b]);
    chk8(fb_div, exp_div[b + 1]);
    chk8(sw_div, exp_div[b + 2]);
  endtask

  function automatic logic [7:0] f_filt(input rss_rate_e r);
    case (r)
      RATE_FSK_100K: return 8'hff;
      RATE_FSK_25K: return 8'ha3;
      RATE_FSK_2K: return 8'h41;
      RATE_OOK_HIGH: return 8'hc1;
      RATE_OOK_LOW: return 8'ha0;
      default: return 8'ha3;
    endcase
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(57));
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    cyc = 0;
    while (dev_ready !== 1'b1 && cyc < 4000) begin
      @(negedge clk);
      cyc++;
    end
    chk1(cyc >= 1000, 1'b1);
    chk1(cyc < 3000, 1'b1);
    chk8(ref_div, 8'h00);
    chk8(rx_filter, 8'ha3);
    chk1(set_sel, 1'b0);
    $display("test power_on done");

    for (int i = 0; i < 6; i++) begin
      exp_div[i] = (i == 0) ? 8'hff : 8'($urandom);
      send(1'b0, RATE_FSK_100K, 8'h06 + 8'(i), exp_div[i]);
    end
    chk_set(0);
    send(1'b0, RATE_FSK_100K, 8'h05, 8'h5a);
    send(1'b0, RATE_FSK_100K, 8'h0c, 8'h77);
    chk_set(0);
    chk8(rx_filter, 8'ha3);
    t0 = $time;
    send(1'b0, RATE_FSK_100K, 8'h00, 8'h01);
    t_slow = $time - t0;
    chk1(set_sel, 1'b1);
    chk_set(3);
    $display("test divider_sets done");

    send(1'b0, RATE_FSK_100K, 8'h00, 8'h03);
    t0 = $time;
    send(1'b0, RATE_FSK_100K, 8'h00, 8'h02);
    // Hop with receiver on must beat the set change with receiver off
    chk1(($time - t0) < t_slow, 1'b1);
    chk_set(0);
    chk1(rx_enable, 1'b1);
    chk1(ready, 1'b1);
    chk1(locked, 1'b1);
    chk1(settle_to, 1'b0);
    $display("test rx_hop done");

    for (int r = 0; r < 5; r++) begin
      send(1'b1, rss_rate_e'(r), 8'h00, 8'h00);
      chk8(rx_filter, f_filt(rss_rate_e'(r)));
    end
    val = 8'($urandom);
    send(1'b0, RATE_FSK_100K, 8'h10, val);
    chk8(rx_filter, val);
    $display("test filter_codes done");

    mrst_req = 1'b1;
    @(negedge clk);
    mrst_req = 1'b0;
    wait_sig(1'b1, 1'b0);
    wait_sig(1'b1, 1'b1);
    chk8(ref_div, 8'h00);
    chk8(rx_filter, 8'ha3);
    chk1(rx_enable, 1'b0);
    send(1'b0, RATE_FSK_100K, 8'h06, val);
    chk8(ref_div, val);
    $display("test manual_reset done");
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule // tb
